/* File: logic/cgoc_core.v */
// Column gain and offset correction: pixel pipeline, mode control and
// user coefficient table with reset and save walks.
// Assumes all control inputs and the pixel stream share the clock clk.
`timescale 1ns/1ps
`include "cgoc_regs.vh"

// What this block does
// R1: Output equals gain times the sum of pixel and offset.
// R2: Coefficients chosen by column, never by row.
// R3: Correction enable control, on after reset.
// R4: Three modes: factory, user, calibration.
// R5: Reset leaves factory mode with factory coefficients.
// R6: Factory coefficients depend on camera gain level.
// R7: User table applies regardless of gain level.
// R8: Default user table leaves pixels unchanged.
// R9: User table access only in calibration.
// R10: Calibration disables correction and locks enable.
// R11: Calibration writes act only in enabled user.
// R12: Column coordinate selects table entry; no row.
// R13: One delta gain stored per column.
// R14: 16-bit offset, step multiples only, else error.
// R15: Software reads step before writing offset.
// R16: Table reset restores saved or default values.
// R17: Table save replaces stored table entirely.
// R18: Software stops streaming before leaving calibration.
// R19: Disabled correction passes pixels, same latency.
// R20: Results clamp to pixel range, never wrap.
module cgoc_core (
	input  wire                    clk,
	input  wire                    rst_n,
	input  wire                    s_valid,
	output wire                    s_ready,
	input  wire [`CGOC_PIX_W-1:0]  s_pix,
	input  wire [`CGOC_COL_W-1:0]  s_col,
	output wire                    m_valid,
	input  wire                    m_ready,
	output wire [`CGOC_PIX_W-1:0]  m_pix,
	input  wire [`CGOC_LVL_W-1:0]  cam_gain_level,
	input  wire                    en_wr,
	input  wire                    en_wdata,
	input  wire                    mode_wr,
	input  wire [1:0]              mode_wdata,
	output wire                    correction_enable,
	output wire [1:0]              correction_mode_select,
	output wire                    correction_active,
	input  wire [`CGOC_COL_W-1:0]  tbl_col,
	input  wire                    gain_wr,
	input  wire                    offset_wr,
	input  wire [`CGOC_COEF_W-1:0] tbl_wdata,
	input  wire                    tbl_rd,
	output wire                    rd_valid,
	output wire [`CGOC_COEF_W-1:0] gain_rdata,
	output wire [`CGOC_COEF_W-1:0] offset_rdata,
	output wire [`CGOC_COEF_W-1:0] offset_step,
	input  wire                    tbl_reset_cmd,
	input  wire                    tbl_save_cmd,
	output wire                    tbl_busy,
	output wire                    ctl_err,
	input  wire                    fac_wr,
	input  wire [`CGOC_LVL_W-1:0]  fac_level,
	input  wire [`CGOC_COL_W-1:0]  fac_col,
	input  wire [`CGOC_COEF_W-1:0] fac_gain,
	input  wire [`CGOC_COEF_W-1:0] fac_offset
);

	localparam ST_IDLE = 2'd0;
	localparam ST_LOAD = 2'd1;
	localparam ST_SAVE = 2'd2;

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	reg  [1:0]              rst_sync_ff;
	wire                    rst_i_n;
	reg                     enable_ff;
	reg  [1:0]              mode_ff;
	reg  [1:0]              st_ff;
	reg  [1:0]              nxt_st;
	reg  [`CGOC_COL_W-1:0]  walk_ff;
	reg                     saved_valid_ff;
	reg                     err_ff;
	reg                     rd_valid_ff;
	reg  [`CGOC_COEF_W-1:0] gain_rd_ff;
	reg  [`CGOC_COEF_W-1:0] off_rd_ff;
	reg  [`CGOC_COEF_W-1:0] usr_gain [0:`CGOC_COLS-1];
	reg  [`CGOC_COEF_W-1:0] usr_off  [0:`CGOC_COLS-1];
	reg  [`CGOC_COEF_W-1:0] sav_gain [0:`CGOC_COLS-1];
	reg  [`CGOC_COEF_W-1:0] sav_off  [0:`CGOC_COLS-1];
	reg  [`CGOC_COEF_W-1:0] fac_g    [0:4*`CGOC_COLS-1];
	reg  [`CGOC_COEF_W-1:0] fac_o    [0:4*`CGOC_COLS-1];
	wire                    cal;
	wire                    busy;
	wire                    acc_req;
	wire                    acc_ok;
	wire                    off_bad;
	wire                    cmd_req;
	wire                    cmd_ok;
	wire                    en_bad;
	wire                    mode_bad;
	wire                    active;
	wire                    f_valid;
	wire [`CGOC_PIX_W+`CGOC_COL_W-1:0] f_data;
	wire                    adv;
	reg                     v1_ff;
	reg                     v2_ff;
	reg                     v3_ff;
	reg  [`CGOC_PIX_W-1:0]  p1_ff;
	reg  [`CGOC_COEF_W-1:0] g1_ff;
	reg  [`CGOC_COEF_W-1:0] o1_ff;
	reg  [`CGOC_SUM_W-1:0]  sum2_ff;
	reg  [`CGOC_COEF_W-1:0] g2_ff;
	reg  [`CGOC_PIX_W-1:0]  out3_ff;
	wire [`CGOC_PIX_W-1:0]  mc_pix;
	wire [`CGOC_COL_W-1:0]  f_col;
	reg  [`CGOC_COEF_W-1:0] sel_gain;
	reg  [`CGOC_COEF_W-1:0] sel_off;

	// Index into the factory arrays from gain level and column.
	function [`CGOC_FAC_AW-1:0] fac_idx;
		input [`CGOC_LVL_W-1:0] lvl;
		input [`CGOC_COL_W-1:0] col;
		begin
			fac_idx = {lvl, col};
		end
	endfunction

	// ----------------------------------------
	// Reset release
	// ----------------------------------------
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			rst_sync_ff <= 2'b00;
		else
			rst_sync_ff <= {rst_sync_ff[0], 1'b1};
	end

	assign rst_i_n = rst_sync_ff[1];

	// ----------------------------------------
	// Control decode
	// ----------------------------------------
	assign cal      = (mode_ff == `CGOC_MODE_CAL);
	assign busy     = (st_ff != ST_IDLE);
	assign acc_req  = gain_wr | offset_wr | tbl_rd;
	assign acc_ok   = cal & ~busy;                                   // [R9]
	assign off_bad  = offset_wr & (tbl_wdata[`CGOC_OFF_STEP_LSB-1:0] != 5'h00); // [R14]
	assign cmd_req  = tbl_reset_cmd | tbl_save_cmd;
	assign cmd_ok   = cal & ~busy;
	assign en_bad   = en_wr & cal;                                   // [R10]
	assign mode_bad = mode_wr & (mode_wdata == 2'h3);                // [R4]
	assign active   = enable_ff & ~cal;                              // [R10] [R11]

	always @(posedge clk or negedge rst_i_n) begin
		if (!rst_i_n) begin
			enable_ff <= 1'b1;                                       // [R3]
			mode_ff   <= `CGOC_MODE_FACTORY;                         // [R5]
			err_ff    <= 1'b0;
		end else begin
			if (en_wr && !cal)
				enable_ff <= en_wdata;                               // [R3]
			if (mode_wr && !mode_bad)
				mode_ff <= mode_wdata;                               // [R4]
			err_ff <= (acc_req & ~acc_ok) | (acc_ok & off_bad) |
			          (cmd_req & ~cmd_ok) | en_bad | mode_bad;       // [R14]
		end
	end

	// ----------------------------------------
	// Table read port
	// ----------------------------------------
	always @(posedge clk or negedge rst_i_n) begin
		if (!rst_i_n) begin
			rd_valid_ff <= 1'b0;
			gain_rd_ff  <= {`CGOC_COEF_W{1'b0}};
			off_rd_ff   <= {`CGOC_COEF_W{1'b0}};
		end else begin
			rd_valid_ff <= tbl_rd & acc_ok;                          // [R9]
			if (tbl_rd && acc_ok) begin
				gain_rd_ff <= usr_gain[tbl_col];                     // [R12] [R13]
				off_rd_ff  <= usr_off[tbl_col];                      // [R12]
			end
		end
	end

	// ----------------------------------------
	// Table walk sequencer
	// ----------------------------------------
	always @* begin
		nxt_st = st_ff;
		case (st_ff)
			ST_IDLE: begin
				if (tbl_reset_cmd && cmd_ok)
					nxt_st = ST_LOAD;                                // [R16]
				else if (tbl_save_cmd && cmd_ok)
					nxt_st = ST_SAVE;                                // [R17]
			end
			ST_LOAD: begin
				if (walk_ff == `CGOC_LAST_COL)
					nxt_st = ST_IDLE;
			end
			ST_SAVE: begin
				if (walk_ff == `CGOC_LAST_COL)
					nxt_st = ST_IDLE;
			end
			default: begin
				nxt_st = ST_IDLE;
			end
		endcase
	end

	// A load walk runs after reset so the user table starts defined.
	always @(posedge clk or negedge rst_i_n) begin
		if (!rst_i_n) begin
			st_ff          <= ST_LOAD;                               // [R8]
			walk_ff        <= {`CGOC_COL_W{1'b0}};
			saved_valid_ff <= 1'b0;
		end else begin
			st_ff <= nxt_st;
			if (busy)
				walk_ff <= walk_ff + 1'b1;
			else
				walk_ff <= {`CGOC_COL_W{1'b0}};
			if (st_ff == ST_SAVE && walk_ff == `CGOC_LAST_COL)
				saved_valid_ff <= 1'b1;                              // [R17]
		end
	end

	// ----------------------------------------
	// Coefficient storage
	// ----------------------------------------
	always @(posedge clk) begin
		if (st_ff == ST_LOAD) begin
			if (saved_valid_ff) begin
				usr_gain[walk_ff] <= sav_gain[walk_ff];              // [R16]
				usr_off[walk_ff]  <= sav_off[walk_ff];
			end else begin
				usr_gain[walk_ff] <= `CGOC_GAIN_UNITY;               // [R8] [R16]
				usr_off[walk_ff]  <= `CGOC_OFF_ZERO;
			end
		end else if (acc_ok) begin
			if (gain_wr)
				usr_gain[tbl_col] <= tbl_wdata;                      // [R13]
			if (offset_wr && !off_bad)
				usr_off[tbl_col] <= tbl_wdata;                       // [R14]
		end
	end

	always @(posedge clk) begin
		if (st_ff == ST_SAVE) begin
			sav_gain[walk_ff] <= usr_gain[walk_ff];                  // [R17]
			sav_off[walk_ff]  <= usr_off[walk_ff];
		end
	end

	always @(posedge clk) begin
		if (fac_wr) begin
			fac_g[fac_idx(fac_level, fac_col)] <= fac_gain;          // [R6]
			fac_o[fac_idx(fac_level, fac_col)] <= fac_offset;
		end
	end

	// ----------------------------------------
	// Input buffer
	// ----------------------------------------
	cgoc_fifo #(
		.W     (`CGOC_PIX_W+`CGOC_COL_W),
		.DEPTH (`CGOC_FIFO_DEPTH),
		.AW    (`CGOC_FIFO_AW)
	) u_fifo (
		.clk       (clk),
		.rst_n     (rst_i_n),
		.in_valid  (s_valid),
		.in_ready  (s_ready),
		.in_data   ({s_col, s_pix}),
		.out_valid (f_valid),
		.out_ready (adv),
		.out_data  (f_data)
	);

	assign f_col = f_data[`CGOC_PIX_W+`CGOC_COL_W-1:`CGOC_PIX_W];

	// ----------------------------------------
	// Coefficient selection
	// ----------------------------------------
	// Disabled correction uses unity gain and zero offset, so pixels take
	// the same path and latency as corrected ones.
	always @* begin
		sel_gain = `CGOC_GAIN_UNITY;                                 // [R19]
		sel_off  = `CGOC_OFF_ZERO;
		if (active) begin
			case (mode_ff)
				`CGOC_MODE_FACTORY: begin
					sel_gain = fac_g[fac_idx(cam_gain_level, f_col)]; // [R2] [R6]
					sel_off  = fac_o[fac_idx(cam_gain_level, f_col)];
				end
				`CGOC_MODE_USER: begin
					sel_gain = usr_gain[f_col];                      // [R2] [R7] [R11]
					sel_off  = usr_off[f_col];
				end
				default: begin
					sel_gain = `CGOC_GAIN_UNITY;
					sel_off  = `CGOC_OFF_ZERO;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Pixel pipeline
	// ----------------------------------------
	// The whole pipeline stalls together when the output is held.
	assign adv = ~v3_ff | m_ready;

	always @(posedge clk or negedge rst_i_n) begin
		if (!rst_i_n) begin
			v1_ff   <= 1'b0;
			v2_ff   <= 1'b0;
			v3_ff   <= 1'b0;
			p1_ff   <= {`CGOC_PIX_W{1'b0}};
			g1_ff   <= {`CGOC_COEF_W{1'b0}};
			o1_ff   <= {`CGOC_COEF_W{1'b0}};
			sum2_ff <= {`CGOC_SUM_W{1'b0}};
			g2_ff   <= {`CGOC_COEF_W{1'b0}};
			out3_ff <= {`CGOC_PIX_W{1'b0}};
		end else if (adv) begin
			v1_ff   <= f_valid;
			v2_ff   <= v1_ff;
			v3_ff   <= v2_ff;
			p1_ff   <= f_data[`CGOC_PIX_W-1:0];
			g1_ff   <= sel_gain;
			o1_ff   <= sel_off;
			sum2_ff <= {{(`CGOC_SUM_W-`CGOC_PIX_W){1'b0}}, p1_ff} +
			           {{(`CGOC_SUM_W-`CGOC_COEF_W){o1_ff[`CGOC_COEF_W-1]}}, o1_ff}; // [R1]
			g2_ff   <= g1_ff;
			out3_ff <= mc_pix;                                       // [R1]
		end
	end

	cgoc_mul_clamp u_mul (
		.sum  (sum2_ff),
		.gain (g2_ff),
		.pix  (mc_pix)                                               // [R20]
	);

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign m_valid                = v3_ff;
	assign m_pix                  = out3_ff;
	assign correction_enable      = enable_ff;
	assign correction_mode_select = mode_ff;
	assign correction_active      = active;
	assign rd_valid               = rd_valid_ff;
	assign gain_rdata             = gain_rd_ff;
	assign offset_rdata           = off_rd_ff;
	assign offset_step            = `CGOC_OFF_STEP;                  // [R15]
	assign tbl_busy               = busy;
	assign ctl_err                = err_ff;

endmodule // cgoc_core

/* File: logic/cgoc_regs.vh */
// Constants of the column gain and offset correction block.
// Assumes inclusion by bare name from each design file of the block.
`ifndef CGOC_REGS_VH
`define CGOC_REGS_VH

// ----------------------------------------
// Widths and sizes
// ----------------------------------------
`define CGOC_PIX_W 12
`define CGOC_PIX_MAX 12'hfff
`define CGOC_COL_W 8
`define CGOC_COLS 256
`define CGOC_LAST_COL 8'hff
`define CGOC_COEF_W 16
`define CGOC_SUM_W 18
`define CGOC_LVL_W 2
`define CGOC_FAC_AW 10

// ----------------------------------------
// Coefficient encoding
// ----------------------------------------
`define CGOC_GAIN_FRAC 14
`define CGOC_GAIN_UNITY 16'h4000
`define CGOC_OFF_ZERO 16'h0000
`define CGOC_OFF_STEP 16'h0020
`define CGOC_OFF_STEP_LSB 5

// ----------------------------------------
// Modes
// ----------------------------------------
`define CGOC_MODE_FACTORY 2'h0
`define CGOC_MODE_USER 2'h1
`define CGOC_MODE_CAL 2'h2

// ----------------------------------------
// Input buffer
// ----------------------------------------
`define CGOC_FIFO_DEPTH 16
`define CGOC_FIFO_AW 4

`endif

/* File: logic/cgoc_fifo.v */
// Synchronous FIFO with valid and ready on both sides.
// Assumes one clock and an active low reset already synchronised.
`timescale 1ns/1ps
module cgoc_fifo #(
	parameter W     = 20,
	parameter DEPTH = 16,
	parameter AW    = 4
) (
	input  wire          clk,
	input  wire          rst_n,
	input  wire          in_valid,
	output wire          in_ready,
	input  wire [W-1:0]  in_data,
	output wire          out_valid,
	input  wire          out_ready,
	output wire [W-1:0]  out_data
);

	reg [W-1:0] mem [0:DEPTH-1];
	reg [AW:0]  wr_ptr_ff;
	reg [AW:0]  rd_ptr_ff;
	wire        full;
	wire        empty;
	wire        push;
	wire        pop;

	// ----------------------------------------
	// Pointers and flags
	// ----------------------------------------
	assign empty     = (wr_ptr_ff == rd_ptr_ff);
	assign full      = (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]) && (wr_ptr_ff[AW] != rd_ptr_ff[AW]);
	assign in_ready  = ~full;
	assign out_valid = ~empty;
	assign push      = in_valid & ~full;
	assign pop       = out_ready & ~empty;
	assign out_data  = mem[rd_ptr_ff[AW-1:0]];

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr_ff <= {(AW+1){1'b0}};
			rd_ptr_ff <= {(AW+1){1'b0}};
		end else begin
			if (push)
				wr_ptr_ff <= wr_ptr_ff + 1'b1;
			if (pop)
				rd_ptr_ff <= rd_ptr_ff + 1'b1;
		end
	end

	always @(posedge clk) begin
		if (push)
			mem[wr_ptr_ff[AW-1:0]] <= in_data;
	end

endmodule // cgoc_fifo

/* File: logic/cgoc_mul_clamp.v */
// Multiplies an offset-corrected pixel by a gain and clamps the result.
// Assumes the gain is unsigned with CGOC_GAIN_FRAC fraction bits.
`timescale 1ns/1ps
`include "cgoc_regs.vh"
module cgoc_mul_clamp (
	input  wire [`CGOC_SUM_W-1:0]  sum,
	input  wire [`CGOC_COEF_W-1:0] gain,
	output reg  [`CGOC_PIX_W-1:0]  pix
);

	wire signed [`CGOC_SUM_W-1:0]  s;
	wire signed [`CGOC_COEF_W:0]   g;
	wire signed [34:0]             p;
	wire signed [20:0]             q;

	assign s = sum;
	assign g = {1'b0, gain};
	assign p = s * g;
	assign q = p[34:`CGOC_GAIN_FRAC];

	// Negative results saturate at zero and large ones at full scale.
	always @* begin
		if (q < 21'sd0)
			pix = {`CGOC_PIX_W{1'b0}};
		else if (q > $signed({9'h000, `CGOC_PIX_MAX}))
			pix = `CGOC_PIX_MAX;
		else
			pix = q[`CGOC_PIX_W-1:0];
	end

endmodule // cgoc_mul_clamp

/* File: testbench/cgoc_core_props.sv */
// Concurrent checks of the correction core, seen from its ports.
// Assumes binding to cgoc_core; rst_n is the raw reset of clk.
`timescale 1ns/1ps
`include "cgoc_regs.vh"
module cgoc_core_props (
	input wire                    clk,
	input wire                    rst_n,
	input wire                    en_wr,
	input wire                    mode_wr,
	input wire [1:0]              mode_wdata,
	input wire                    correction_enable,
	input wire [1:0]              correction_mode_select,
	input wire                    correction_active,
	input wire                    gain_wr,
	input wire                    offset_wr,
	input wire [`CGOC_COEF_W-1:0] tbl_wdata,
	input wire                    tbl_rd,
	input wire                    rd_valid,
	input wire [`CGOC_COEF_W-1:0] offset_step,
	input wire                    tbl_save_cmd,
	input wire                    tbl_busy,
	input wire                    ctl_err
);
default clocking cb @(posedge clk); endclocking
default disable iff (!rst_n);
wire cal = correction_mode_select == `CGOC_MODE_CAL;
property p_active; correction_active == (correction_enable && !cal); endproperty
a_active: assert property (p_active) else $error("active flag wrong");
property p_step; offset_step == `CGOC_OFF_STEP; endproperty
a_step: assert property (p_step) else $error("offset step wrong");
property p_bad_off; offset_wr && tbl_wdata[4:0] != 5'h00 |=> ctl_err; endproperty
a_bad_off: assert property (p_bad_off) else $error("bad offset not refused");
property p_acc_out; (gain_wr || tbl_rd) && !cal |=> ctl_err; endproperty
a_acc_out: assert property (p_acc_out) else $error("access outside calibration not refused");
property p_rd; tbl_rd && cal && !tbl_busy |=> rd_valid && !ctl_err; endproperty
a_rd: assert property (p_rd) else $error("read not answered");
property p_save; tbl_save_cmd && cal && !tbl_busy |=> tbl_busy [*8]; endproperty
a_save: assert property (p_save) else $error("save walk not busy");
property p_en_lock; en_wr && cal |=> ctl_err && $stable(correction_enable); endproperty
a_en_lock: assert property (p_en_lock) else $error("enable not locked");
property p_mode3; mode_wr && mode_wdata == 2'h3 |=> ctl_err && $stable(correction_mode_select); endproperty
a_mode3: assert property (p_mode3) else $error("illegal mode taken");
property p_mode_wr; mode_wr && mode_wdata != 2'h3 |=> correction_mode_select == $past(mode_wdata); endproperty
a_mode_wr: assert property (p_mode_wr) else $error("mode not taken");
c_rd: cover property (rd_valid);
c_walk: cover property ($rose(tbl_busy) && cal);
c_err: cover property (ctl_err);
endmodule // cgoc_core_props
bind cgoc_core cgoc_core_props u_props (.clk(clk), .rst_n(rst_n), .en_wr(en_wr), .mode_wr(mode_wr),
	.mode_wdata(mode_wdata), .correction_enable(correction_enable),
	.correction_mode_select(correction_mode_select), .correction_active(correction_active),
	.gain_wr(gain_wr), .offset_wr(offset_wr), .tbl_wdata(tbl_wdata), .tbl_rd(tbl_rd),
	.rd_valid(rd_valid), .offset_step(offset_step), .tbl_save_cmd(tbl_save_cmd),
	.tbl_busy(tbl_busy), .ctl_err(ctl_err));

/* File: testbench/cgoc_pix_sink.sv */
// Pixel sink model standing after the correction core.
// Assumes the bench commands stalls through stall.
`timescale 1ns/1ps
`include "cgoc_regs.vh"
module cgoc_pix_sink (
	input  wire                   clk,
	input  wire                   stall,
	input  wire                   m_valid,
	output wire                   m_ready,
	input  wire [`CGOC_PIX_W-1:0] m_pix,
	output reg                    got_ff,
	output reg  [`CGOC_PIX_W-1:0] got_pix_ff
);
assign m_ready = !stall;
initial got_ff = 1'b0;
always @(posedge clk) begin
	got_ff     <= m_valid && m_ready;
	got_pix_ff <= m_pix;
end
endmodule // cgoc_pix_sink

/* File: testbench/tb_top.sv */
// Self-checking bench of the correction core with a pixel sink model.
// Assumes the core, FIFO and multiplier sources are compiled first.
`timescale 1ns/1ps
`include "cgoc_regs.vh"
module tb_top;
reg        clk = 1'b0, rst_n = 1'b0, s_valid = 1'b0, en_wr = 1'b0, en_wdata = 1'b0, mode_wr = 1'b0;
reg        gain_wr = 1'b0, offset_wr = 1'b0, tbl_rd = 1'b0, tbl_reset_cmd = 1'b0, tbl_save_cmd = 1'b0;
reg        fac_wr = 1'b0, stall = 1'b0;
reg [1:0]  mode_wdata = 2'h0, cam_gain_level = 2'h0, fac_level = 2'h0;
reg [7:0]  s_col = 8'h00, tbl_col = 8'h00, fac_col = 8'h00;
reg [11:0] s_pix = 12'h000;
reg [15:0] tbl_wdata = 16'h0000, fac_gain = 16'h0000, fac_offset = 16'h0000;
wire        s_ready, m_valid, m_ready, correction_enable, correction_active, rd_valid, tbl_busy, ctl_err, got;
wire [1:0]  correction_mode_select;
wire [11:0] m_pix, got_pix;
wire [15:0] gain_rdata, offset_rdata, offset_step;
int mismatches = 0;
int checks_done = 0;
always #4 clk = ~clk;
cgoc_core u_dut (.clk(clk), .rst_n(rst_n), .s_valid(s_valid), .s_ready(s_ready), .s_pix(s_pix),
	.s_col(s_col), .m_valid(m_valid), .m_ready(m_ready), .m_pix(m_pix), .cam_gain_level(cam_gain_level),
	.en_wr(en_wr), .en_wdata(en_wdata), .mode_wr(mode_wr), .mode_wdata(mode_wdata),
	.correction_enable(correction_enable), .correction_mode_select(correction_mode_select),
	.correction_active(correction_active), .tbl_col(tbl_col), .gain_wr(gain_wr), .offset_wr(offset_wr),
	.tbl_wdata(tbl_wdata), .tbl_rd(tbl_rd), .rd_valid(rd_valid), .gain_rdata(gain_rdata),
	.offset_rdata(offset_rdata), .offset_step(offset_step), .tbl_reset_cmd(tbl_reset_cmd),
	.tbl_save_cmd(tbl_save_cmd), .tbl_busy(tbl_busy), .ctl_err(ctl_err), .fac_wr(fac_wr),
	.fac_level(fac_level), .fac_col(fac_col), .fac_gain(fac_gain), .fac_offset(fac_offset));
cgoc_pix_sink u_sink (.clk(clk), .stall(stall), .m_valid(m_valid), .m_ready(m_ready), .m_pix(m_pix),
	.got_ff(got), .got_pix_ff(got_pix));
// ----------------------------------------
// Shared tasks
// ----------------------------------------
task wrap_up;
	$display("checks %0d mismatches %0d", checks_done, mismatches);
	if (mismatches == 0 && checks_done > 0)
		$display("All tests passed");
	else
		$display("Some tests failed");
	$finish;
endtask
task cmp(input string what, input [15:0] exp, input [15:0] seen);
	checks_done++;
	if (seen !== exp) begin
		mismatches++;
		$display("unexpected %s: expected %h seen %h", what, exp, seen);
	end
endtask
task lost;
	mismatches++;
	$display("unexpected wait: expected done seen timeout");
	wrap_up;
endtask
task tick;
	@(posedge clk);
endtask
task err_is(input e);
	@(negedge clk);
	cmp("ctl_err", {15'h0, e}, {15'h0, ctl_err});
endtask
task set_mode(input [1:0] m);
	tick;
	mode_wr <= 1'b1;
	mode_wdata <= m;
	tick;
	mode_wr <= 1'b0;
endtask
task set_en(input v);
	tick;
	en_wr <= 1'b1;
	en_wdata <= v;
	tick;
	en_wr <= 1'b0;
endtask
task acc(input g, input o, input r, input [7:0] c, input [15:0] d);
	tick;
	gain_wr <= g;
	offset_wr <= o;
	tbl_rd <= r;
	tbl_col <= c;
	tbl_wdata <= d;
	tick;
	gain_wr <= 1'b0;
	offset_wr <= 1'b0;
	tbl_rd <= 1'b0;
endtask
task fac(input [1:0] l, input [7:0] c, input [15:0] g, input [15:0] o);
	tick;
	fac_wr <= 1'b1;
	fac_level <= l;
	fac_col <= c;
	fac_gain <= g;
	fac_offset <= o;
	tick;
	fac_wr <= 1'b0;
endtask
task idle(output int n);
	n = 0;
	repeat (600) begin
		@(negedge clk);
		if (tbl_busy !== 1'b1)
			return;
		n++;
	end
	lost;
endtask
task cmd(input rs, input sv);
	int n;
	tick;
	tbl_reset_cmd <= rs;
	tbl_save_cmd <= sv;
	tick;
	tbl_reset_cmd <= 1'b0;
	tbl_save_cmd <= 1'b0;
	idle(n);
	cmp("busy_cycles", 16'd256, n[15:0]);
endtask
function [11:0] fcalc(input [11:0] p, input [15:0] off, input [15:0] g);
	reg signed [40:0] v;
	v = ($signed({1'b0, p}) + $signed(off)) * $signed({1'b0, g});
	v = v >>> 14;
	fcalc = (v < 0) ? 12'h000 : (v > 41'sd4095) ? 12'hfff : v[11:0];
endfunction
task px(input [11:0] p, input [7:0] c, input [11:0] e);
	int i;
	tick;
	s_valid <= 1'b1;
	s_pix <= p;
	s_col <= c;
	for (i = 0; i < 50; i++) begin
		@(negedge clk);
		if (s_ready === 1'b1)
			break;
	end
	if (i == 50)
		lost;
	tick;
	s_valid <= 1'b0;
	for (i = 0; i < 50 && got !== 1'b1; i++)
		@(negedge clk);
	if (i == 50)
		lost;
	cmp("latency", 16'd5, i[15:0]);
	cmp("m_pix", {4'h0, e}, {4'h0, got_pix});
endtask
// ----------------------------------------
// Scenarios
// ----------------------------------------
task t_reset;
	int n;
	@(negedge clk);
	cmp("enable", 16'h0001, {15'h0, correction_enable});
	cmp("mode", {14'h0, `CGOC_MODE_FACTORY}, {14'h0, correction_mode_select});
	idle(n);
	$display("test reset finished");
endtask
task t_factory;
	int l;
	for (l = 0; l < 4; l++)
		fac(l[1:0], 8'h03, 16'h4000 + l[15:0] * 16'h2000, l[15:0] * 16'h0020);
	fac(2'h0, 8'h04, 16'h8000, 16'h0000);
	px(12'd100, 8'h04, 12'd200);
	for (l = 0; l < 4; l++) begin
		tick;
		cam_gain_level <= l[1:0];
		px(12'd1500, 8'h03, fcalc(12'd1500, l[15:0] * 16'h0020, 16'h4000 + l[15:0] * 16'h2000));
	end
	px(12'd3000, 8'h03, 12'hfff);
	fac(2'h3, 8'h04, 16'h4000, 16'hff00);
	px(12'd100, 8'h04, 12'h000);
	set_en(1'b0);
	px(12'd3000, 8'h03, 12'd3000);
	set_en(1'b1);
	$display("test factory finished");
endtask
task t_cal;
	set_mode(`CGOC_MODE_CAL);
	err_is(1'b0);
	cmp("active", 16'h0000, {15'h0, correction_active});
	set_en(1'b0);
	err_is(1'b1);
	cmp("enable", 16'h0001, {15'h0, correction_enable});
	set_mode(2'h3);
	err_is(1'b1);
	cmp("mode", {14'h0, `CGOC_MODE_CAL}, {14'h0, correction_mode_select});
	acc(1'b0, 1'b0, 1'b1, 8'h05, 16'h0000);
	err_is(1'b0);
	cmp("rd_valid", 16'h0001, {15'h0, rd_valid});
	cmp("gain", `CGOC_GAIN_UNITY, gain_rdata);
	cmp("offset", `CGOC_OFF_ZERO, offset_rdata);
	cmp("step", `CGOC_OFF_STEP, offset_step);
	acc(1'b1, 1'b0, 1'b0, 8'h05, 16'h8000);
	acc(1'b0, 1'b1, 1'b0, 8'h05, 16'h0040);
	acc(1'b0, 1'b1, 1'b0, 8'h05, 16'h0041);
	err_is(1'b1);
	acc(1'b0, 1'b0, 1'b1, 8'h05, 16'h0000);
	err_is(1'b0);
	cmp("gain", 16'h8000, gain_rdata);
	cmp("offset", 16'h0040, offset_rdata);
	px(12'd100, 8'h05, 12'd100);
	set_mode(`CGOC_MODE_USER);
	px(12'd100, 8'h05, fcalc(12'd100, 16'h0040, 16'h8000));
	tick;
	cam_gain_level <= 2'h1;
	px(12'd100, 8'h05, fcalc(12'd100, 16'h0040, 16'h8000));
	px(12'd100, 8'h06, 12'd100);
	acc(1'b0, 1'b0, 1'b1, 8'h05, 16'h0000);
	err_is(1'b1);
	$display("test calibration finished");
endtask
task t_cmds;
	set_mode(`CGOC_MODE_CAL);
	cmd(1'b1, 1'b0);
	acc(1'b0, 1'b0, 1'b1, 8'h05, 16'h0000);
	err_is(1'b0);
	cmp("gain", `CGOC_GAIN_UNITY, gain_rdata);
	acc(1'b1, 1'b0, 1'b0, 8'h05, 16'h8000);
	cmd(1'b0, 1'b1);
	acc(1'b1, 1'b0, 1'b0, 8'h05, 16'h2000);
	cmd(1'b1, 1'b0);
	acc(1'b0, 1'b0, 1'b1, 8'h05, 16'h0000);
	err_is(1'b0);
	cmp("gain", 16'h8000, gain_rdata);
	$display("test commands finished");
endtask
task t_fifo;
	int n, k;
	tick;
	stall <= 1'b1;
	s_valid <= 1'b1;
	s_col <= 8'h07;
	s_pix <= 12'h000;
	n = 0;
	for (k = 0; k < 40; k++) begin
		@(negedge clk);
		if (s_ready !== 1'b1)
			break;
		tick;
		n++;
		s_pix <= n[11:0];
	end
	tick;
	s_valid <= 1'b0;
	stall <= 1'b0;
	cmp("refused", 16'h0001, {15'h0, k < 40});
	cmp("room", 16'h0001, {15'h0, n >= `CGOC_FIFO_DEPTH});
	k = 0;
	for (int t = 0; t < 200 && k < n; t++) begin
		@(negedge clk);
		if (got === 1'b1) begin
			cmp("drain_pix", k[15:0], {4'h0, got_pix});
			k++;
		end
	end
	cmp("drain_count", n[15:0], k[15:0]);
	$display("test fifo finished");
endtask
initial begin
	repeat (20) tick;
	rst_n <= 1'b1;
	t_reset;
	t_factory;
	t_cal;
	t_cmds;
	t_fifo;
	wrap_up;
end
endmodule // tb_top
